// ===== design/sar_adc_pkg.sv
// package for the converter control block: timing counts, pin carrier,
// mode and phase enumerations, the block state record and shared functions.
// assumes a single 20 MHz system clock with synchronous reset.
package sar_adc_pkg;

    localparam int CLK_MHZ     = 20;
    localparam int RES_BITS    = 16;
    // one bit decision: comparator settles and crosses the two-stage sampler
    localparam int BIT_TIME_NS = 150;
    localparam int BIT_CYCLES  = (BIT_TIME_NS * CLK_MHZ + 999) / 1000;
    // acquisition timed by the block itself when self-running
    localparam int ACQ_TIME_NS = 400;
    localparam int ACQ_CYCLES  = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_CYCLES = RES_BITS * BIT_CYCLES + 1;
    localparam int SUB_W       = $clog2(BIT_CYCLES + 1);
    localparam int ACQ_W       = $clog2(ACQ_CYCLES + 1);

    localparam logic [SUB_W-1:0] SUB_LAST    = SUB_W'(BIT_CYCLES - 1);
    localparam logic [ACQ_W-1:0] ACQ_LAST    = ACQ_W'(ACQ_CYCLES);
    localparam logic [4:0]       SERIAL_BITS = 5'h10;
    localparam logic [3:0]       MSB_INDEX   = 4'hf;
    localparam int               SERIAL_PIN_BIT  = 15;
    localparam logic [15:0]      SERIAL_PIN_MASK = 16'h8000;
    localparam logic [15:0]      TRIAL_FIRST = 16'h8000;
    localparam logic [15:0]      SIGN_FLIP   = 16'h8000;
    localparam logic [15:0]      WORD_RESET  = 16'h0000;

    typedef struct packed {
        logic cnvN;
        logic pwrDown;
        logic lp;
        logic fast;
        logic ob;
        logic sp;
        logic csN;
        logic rdN;
        logic sclk;
        logic comp;
    } pins_t;

    localparam pins_t PIN_RST = '{cnvN: 1'b1, pwrDown: 1'b0, lp: 1'b0, fast: 1'b0, ob: 1'b1,
                                  sp: 1'b0, csN: 1'b1, rdN: 1'b1, sclk: 1'b0, comp: 1'b0};

    typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_CODE}             phase_t;
    typedef enum logic [1:0] {MODE_NORMAL, MODE_FAST, MODE_LOWPOWER} mode_t;

    typedef struct packed {
        pins_t            s1;
        pins_t            s2;
        logic             cnvPrev;
        logic             sclkPrev;
        phase_t           phase;
        logic [3:0]       bitIdx;
        logic [SUB_W-1:0] subCnt;
        logic [ACQ_W-1:0] acqCnt;
        logic [15:0]      sar;
        logic [15:0]      result;
        logic             busy;
        logic             armed;
        logic             powerReduced;
        logic [4:0]       shiftCnt;
        logic [15:0]      dataOut;
    } state_t;

    localparam state_t STATE_RST = '{s1: PIN_RST, s2: PIN_RST, cnvPrev: 1'b1, sclkPrev: 1'b0,
                                     phase: ST_ACQ, bitIdx: 4'h0, subCnt: '0, acqCnt: '0,
                                     sar: WORD_RESET, result: WORD_RESET, busy: 1'b0,
                                     armed: 1'b0, powerReduced: 1'b0, shiftCnt: 5'h00,
                                     dataOut: WORD_RESET};

    function automatic mode_t decodeMode(input logic lp, input logic fast);
        if (lp)
            return MODE_LOWPOWER;
        else if (fast)
            return MODE_FAST;
        else
            return MODE_NORMAL;
    endfunction

    // straight binary when ob is high, otherwise midscale maps to zero
    function automatic logic [15:0] codeOf(input logic [15:0] raw, input logic ob);
        return ob ? raw : (raw ^ SIGN_FLIP);
    endfunction

    function automatic logic [15:0] bitMask(input logic [3:0] idx);
        return 16'(16'h0001 << idx);
    endfunction

endpackage

// ===== design/sar_adc_conversion_readout.sv
// converter control and host readout: start and busy sequencing, self-running
// low-power loop, result coding, parallel bus and serial shift-out.
// assumes all pins, the comparator and the serial clock are asynchronous to clk.
`timescale 1ns/10ps

// Function
// - a started conversion always completes; new start or power-down cannot abort it
// - convert-start works whatever chip-select and read are doing
// - low-power mode with start held low times acquisition and relaunches itself
// - fast and normal modes never relaunch; each conversion needs its own start
// - self-running rate may slightly exceed the guaranteed low-power rate
// - low-power mode reduces converter power after every conversion
// - host interface keeps working during acquisition and reduced power
// - chip-select or read high puts every data bus output in high impedance
// - chip-select and read low place the result on the data bus
// - coding input picks straight binary or two's complement
// - serial output shares a data bus pin instead of the parallel function
// - select low presents results on the parallel bus
// - parallel result readable after conversion, during acquisition or next conversion
// - select high delivers results on the serial output pin
// - serial result is 16 bits, msb first, one bit per clock pulse
// - each serial bit holds across both edges of its clock pulse
// - falling convert-start ends acquisition and begins conversion
// - after the last bit decision the code is formed, then busy drops
// - both mode selects low choose the normal mode
// - midscale is 8000 straight binary and full scale 7fff two's complement
module sar_adc_conversion_readout
    import sar_adc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        convertStartN,
    input  wire logic        powerDownIn,
    input  wire logic        lowPowerModeSelect,
    input  wire logic        fastModeSelect,
    input  wire logic        outputCodingSelect,
    input  wire logic        serialParallelSelect,
    input  wire logic        chipSelectN,
    input  wire logic        readN,
    input  wire logic        serialClock,
    input  wire logic        comparatorHigh,
    output logic             busy,
    output logic [15:0]      dacTrial,
    output logic             converterPowerReduced,
    output logic [15:0]      dataOut,
    output logic [15:0]      dataOe
);

    ////////////////////////////////////////////////////////////////////////////
    // state record

    state_t st;
    state_t next_st;
    pins_t  pinsIn;
    mode_t  mode;
    logic   selected;
    logic   cnvFell;
    logic   sclkFell;
    logic   edgeStart;
    logic   autoStart;
    logic [15:0] decided;

    assign pinsIn = '{cnvN: convertStartN, pwrDown: powerDownIn, lp: lowPowerModeSelect,
                      fast: fastModeSelect, ob: outputCodingSelect,
                      sp: serialParallelSelect, csN: chipSelectN, rdN: readN,
                      sclk: serialClock, comp: comparatorHigh};

    assign mode     = decodeMode(st.s2.lp, st.s2.fast);
    assign selected = !st.s2.csN && !st.s2.rdN;
    assign cnvFell  = st.cnvPrev && !st.s2.cnvN;
    assign sclkFell = st.sclkPrev && !st.s2.sclk;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_st          = st;
        // first stage feeds only the second stage
        next_st.s1       = pinsIn;
        next_st.s2       = st.s1;
        next_st.cnvPrev  = st.s2.cnvN;
        next_st.sclkPrev = st.s2.sclk;

        // chip-select and read play no part in starting a conversion
        edgeStart = cnvFell;
        // self-launch only after a host edge armed the loop, and only in low power
        autoStart = (mode == MODE_LOWPOWER) && st.armed && !st.s2.cnvN
                    && (st.acqCnt == ACQ_LAST);

        decided = st.s2.comp ? st.sar : (st.sar & ~bitMask(st.bitIdx));
        if (st.bitIdx != 4'h0)
            decided = decided | bitMask(4'(st.bitIdx - 4'h1));

        // serial bit counter: restarts whenever the host deselects
        if (!selected) begin
            next_st.shiftCnt = 5'h00;
        end else if (st.s2.sp && sclkFell && (st.shiftCnt < SERIAL_BITS)) begin
            next_st.shiftCnt = 5'(st.shiftCnt + 5'h01);
        end

        unique case (st.phase)
            ST_ACQ: begin
                if (st.acqCnt != ACQ_LAST)
                    next_st.acqCnt = ACQ_W'(st.acqCnt + 1'b1);
                if (st.s2.cnvN)
                    next_st.armed = 1'b0;
                if (st.s2.pwrDown)
                    next_st.powerReduced = 1'b1;
                else if (mode != MODE_LOWPOWER)
                    next_st.powerReduced = 1'b0;
                // power-down holds off new starts but only while acquiring
                if (!st.s2.pwrDown && (edgeStart || autoStart)) begin
                    next_st.phase        = ST_CONV;
                    next_st.bitIdx       = MSB_INDEX;
                    next_st.subCnt       = '0;
                    next_st.sar          = TRIAL_FIRST;
                    next_st.busy         = 1'b1;
                    next_st.armed        = 1'b1;
                    next_st.powerReduced = 1'b0;
                end
            end
            ST_CONV: begin
                // no input is looked at here except the comparator
                next_st.subCnt = SUB_W'(st.subCnt + 1'b1);
                if (st.subCnt == SUB_LAST) begin
                    next_st.subCnt = '0;
                    next_st.sar    = decided;
                    next_st.bitIdx = 4'(st.bitIdx - 4'h1);
                    if (st.bitIdx == 4'h0)
                        next_st.phase = ST_CODE;
                end
            end
            ST_CODE: begin
                // previous result stays readable until this cycle
                next_st.result       = codeOf(st.sar, st.s2.ob);
                next_st.busy         = 1'b0;
                next_st.phase        = ST_ACQ;
                next_st.acqCnt       = '0;
                next_st.shiftCnt     = 5'h00;
                next_st.powerReduced = (mode == MODE_LOWPOWER);
            end
        endcase

        // output register runs regardless of converter power
        if (st.s2.sp) begin
            next_st.dataOut = WORD_RESET;
            if (st.shiftCnt < SERIAL_BITS)
                next_st.dataOut[SERIAL_PIN_BIT] =
                    st.result[4'(MSB_INDEX - st.shiftCnt[3:0])];
        end else begin
            next_st.dataOut = st.result;
        end
    end

    always_ff @(posedge clk) begin
        if (srst)
            st <= STATE_RST;
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign busy                  = st.busy;
    assign dacTrial              = st.sar;
    assign converterPowerReduced = st.powerReduced;
    assign dataOut               = st.dataOut;
    // bus released unless both selects are low; serial uses one shared pin
    assign dataOe = !selected ? WORD_RESET
                              : (st.s2.sp ? SERIAL_PIN_MASK : 16'hffff);

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [7:0] busyLen;
    logic       selfRun;

    always_ff @(posedge clk) begin
        if (srst)
            busyLen <= 8'h00;
        else if (st.busy)
            busyLen <= 8'(busyLen + 8'h01);
        else
            busyLen <= 8'h00;
    end

    assign selfRun = (mode == MODE_LOWPOWER) && !st.s2.cnvN && !st.s2.pwrDown;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_busy_width;
        $fell(st.busy) |-> (busyLen == 8'(CONV_CYCLES));
    endproperty
    a_busy_width: assert property (p_busy_width)
        else $error("busy width differs from full conversion length");

    property p_edge_start;
        (st.phase == ST_ACQ && !st.s2.pwrDown && cnvFell) |=> st.busy ##1 st.busy[*8];
    endproperty
    a_edge_start: assert property (p_edge_start)
        else $error("falling convert-start did not start a held conversion");

    property p_no_relaunch;
        ($fell(st.busy) && mode != MODE_LOWPOWER && !st.s2.cnvN && !cnvFell) ##1 !st.s2.cnvN
            |-> !st.busy;
    endproperty
    a_no_relaunch: assert property (p_no_relaunch)
        else $error("conversion relaunched outside low-power mode");

    property p_self_run;
        ($fell(st.busy) && selfRun) |=> ##[0:12] (st.busy || !selfRun);
    endproperty
    a_self_run: assert property (p_self_run)
        else $error("low-power loop failed to relaunch");

    property p_power_reduce;
        ($fell(st.busy) && mode == MODE_LOWPOWER) |-> converterPowerReduced;
    endproperty
    a_power_reduce: assert property (p_power_reduce)
        else $error("power not reduced after low-power conversion");

    property p_hiz;
        (st.s2.csN || st.s2.rdN) |-> (dataOe == 16'h0000);
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("outputs driven while deselected");

    property p_serial_pin;
        (selected && st.s2.sp) |-> (dataOe == SERIAL_PIN_MASK);
    endproperty
    a_serial_pin: assert property (p_serial_pin)
        else $error("serial mode drives more than the shared pin");

    property p_parallel_data;
        (selected && !st.s2.sp) ##1 (selected && !st.s2.sp)
            |-> (dataOe == 16'hffff) && (dataOut == $past(st.result));
    endproperty
    a_parallel_data: assert property (p_parallel_data)
        else $error("parallel bus does not show the result");

    property p_coding;
        (st.phase == ST_CODE && st.sar == 16'h8000 && !st.s2.ob) |=> (st.result == 16'h0000);
    endproperty
    a_coding: assert property (p_coding)
        else $error("midscale not coded as zero in two's complement");

    property p_serial_msb;
        (selected && st.s2.sp && st.shiftCnt == 5'h00 && st.phase != ST_CODE)
            |=> (dataOut[SERIAL_PIN_BIT] == $past(st.result[15]));
    endproperty
    a_serial_msb: assert property (p_serial_msb)
        else $error("serial output does not lead with the msb");

    property p_serial_hold;
        (selected && st.s2.sp && st.s2.sclk && st.sclkPrev && $past(st.sclkPrev)
            && $past(selected) && st.phase == ST_ACQ && $past(st.phase) == ST_ACQ)
            |-> $stable(dataOut);
    endproperty
    a_serial_hold: assert property (p_serial_hold)
        else $error("serial bit changed while its clock was high");

    property p_first_trial;
        $rose(st.busy) |-> (st.phase == ST_CONV) && (dacTrial == TRIAL_FIRST);
    endproperty
    a_first_trial: assert property (p_first_trial)
        else $error("conversion did not open with the msb trial");

    property p_busy_brackets;
        (st.phase != ST_ACQ) |-> st.busy;
    endproperty
    a_busy_brackets: assert property (p_busy_brackets)
        else $error("busy low while a conversion is running");

    property p_powerdown_hold;
        (st.phase == ST_CONV && st.s2.pwrDown) |=> (st.phase != ST_ACQ);
    endproperty
    a_powerdown_hold: assert property (p_powerdown_hold)
        else $error("power-down aborted a running conversion");

    // a restart would reload the msb index in the middle of the search
    property p_no_restart;
        (st.phase == ST_CONV && st.bitIdx != MSB_INDEX)
            |=> (st.bitIdx != MSB_INDEX) || (st.phase == ST_CODE);
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("conversion restarted before completion");

    property p_code_after_last;
        (st.phase == ST_CONV && st.bitIdx == 4'h0 && st.subCnt == SUB_LAST)
            |=> (st.phase == ST_CODE) && st.busy;
    endproperty
    a_code_after_last: assert property (p_code_after_last)
        else $error("code not formed after the last bit decision");

    property p_busy_drop;
        (st.phase == ST_CODE) |=> (!st.busy && st.phase == ST_ACQ);
    endproperty
    a_busy_drop: assert property (p_busy_drop)
        else $error("busy did not drop once the code was formed");

    property p_straight;
        (st.phase == ST_CODE && st.s2.ob) |=> (st.result == $past(st.sar));
    endproperty
    a_straight: assert property (p_straight)
        else $error("straight binary result differs from the search word");

    property p_twos_full;
        (st.phase == ST_CODE && st.sar == 16'hffff && !st.s2.ob) |=> (st.result == 16'h7fff);
    endproperty
    a_twos_full: assert property (p_twos_full)
        else $error("full scale not coded as 7fff in two's complement");

    property p_result_held;
        (st.phase != ST_CODE) |=> $stable(st.result);
    endproperty
    a_result_held: assert property (p_result_held)
        else $error("result changed outside the coding cycle");

    property p_serial_rest;
        st.s2.sp |=> (dataOut[14:0] == 15'h0000);
    endproperty
    a_serial_rest: assert property (p_serial_rest)
        else $error("serial mode shows data off the shared pin");

    property p_serial_stop;
        (st.s2.sp && st.shiftCnt == SERIAL_BITS) |=> !dataOut[SERIAL_PIN_BIT];
    endproperty
    a_serial_stop: assert property (p_serial_stop)
        else $error("serial output active after the sixteenth pulse");

    property p_deselect_msb;
        !selected |=> (st.shiftCnt == 5'h00);
    endproperty
    a_deselect_msb: assert property (p_deselect_msb)
        else $error("deselect did not return the serial word to its msb");

    property p_no_auto;
        (st.phase == ST_ACQ && mode != MODE_LOWPOWER && !cnvFell) |=> !st.busy;
    endproperty
    a_no_auto: assert property (p_no_auto)
        else $error("conversion launched without a start edge");

    c_self_loop: cover property ($fell(st.busy) && selfRun ##[1:12] $rose(st.busy));
    c_serial_all: cover property (selected && st.s2.sp && st.shiftCnt == SERIAL_BITS);
    c_read_during: cover property (selected && !st.s2.sp && st.busy);
    c_twos: cover property (st.phase == ST_CODE && !st.s2.ob);
    c_fast_start: cover property (mode == MODE_FAST && $rose(st.busy));

endmodule // sar_adc_conversion_readout

// ===== test/host_side_model.sv
// host side of the block: ideal comparator on the held sample, and a host
// that clocks the serial result out. the clock stays parked low between frames.
`timescale 1ns/10ps
module host_side_model (
    input  wire logic [15:0] analogLevel,
    input  wire logic [15:0] dacTrial,
    input  wire logic        serialData,
    output logic             comparatorHigh,
    output logic             serialClock
);
    int edgeMismatch = 0;

    ////////////////////////////////////////////////////////////////////////////
    // a trial at or below the held sample keeps its bit, so the search ends on it
    assign comparatorHigh = (analogLevel >= dacTrial);

    initial serialClock = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // 400 ns pulses, low part longer so the next bit has settled before the rise
    task automatic readWord(output logic [15:0] word);
        logic atRise;
        // keep pin edges clear of the system clock edges
        #10;
        for (int k = 15; k >= 0; k--) begin
            #250 serialClock = 1'b1;
            atRise = serialData;
            #140 word[k] = serialData;
            if (atRise !== word[k])
                edgeMismatch++;
            #10 serialClock = 1'b0;
        end
    endtask
endmodule // host_side_model

// ===== test/sar_adc_conversion_readout_test.sv
// self-checking bench for the converter control and readout block
// assumes the host side model supplies the comparator and the serial clock
`timescale 1ns/10ps
module sar_adc_conversion_readout_test;
    import sar_adc_pkg::*;
    logic        clk, srst, convertStartN, powerDownIn, lowPowerModeSelect, fastModeSelect;
    logic        outputCodingSelect, serialParallelSelect, chipSelectN, readN;
    logic        serialClock, comparatorHigh, busy, converterPowerReduced;
    logic [15:0] dacTrial, dataOut, dataOe, analogLevel, word;
    int          nFail = 0;
    int          numChecks = 0;
    int          cycles = 0;
    int          len;

    sar_adc_conversion_readout i_sar_adc_conversion_readout (.clk(clk), .srst(srst),
        .convertStartN(convertStartN), .powerDownIn(powerDownIn),
        .lowPowerModeSelect(lowPowerModeSelect), .fastModeSelect(fastModeSelect),
        .outputCodingSelect(outputCodingSelect), .serialParallelSelect(serialParallelSelect),
        .chipSelectN(chipSelectN), .readN(readN), .serialClock(serialClock),
        .comparatorHigh(comparatorHigh), .busy(busy), .dacTrial(dacTrial),
        .converterPowerReduced(converterPowerReduced), .dataOut(dataOut), .dataOe(dataOe));

    host_side_model i_host_side_model (.analogLevel(analogLevel), .dacTrial(dacTrial),
        .serialData(dataOut[15]), .comparatorHigh(comparatorHigh), .serialClock(serialClock));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // whole run is under 2000 cycles; anything far beyond that is a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            nFail++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        numChecks++;
        if (got !== exp) begin
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
            nFail++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // start pin falls; busy is then timed edge by edge until it drops
    task automatic convert(input logic [15:0] lvl, input logic keepLow, output int n);
        int w;
        w = 0;
        n = 0;
        @(posedge clk);
        analogLevel <= lvl;
        convertStartN <= 1'b0;
        while (busy !== 1'b1 && w < 10) begin
            @(posedge clk);
            w++;
        end
        if (!keepLow)
            convertStartN <= 1'b1;
        while (busy === 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // both codings at midscale and full scale, read with the bus deselected meanwhile
    task automatic t_coding();
        logic [15:0] lvl;
        for (int i = 0; i < 4; i++) begin
            lvl = (i < 2) ? 16'h8000 : 16'hffff;
            outputCodingSelect <= ~i[0];
            convert(lvl, 1'b0, len);
            chk(16'(len), 16'h0031);
            chk(dacTrial, lvl);
            chipSelectN <= 1'b0;
            readN <= 1'b0;
            tick(5);
            chk(dataOe, 16'hffff);
            chk(dataOut, i[0] ? lvl ^ 16'h8000 : lvl);
            if (i[0])
                readN <= 1'b1;
            else
                chipSelectN <= 1'b1;
            tick(5);
            chk(dataOe, 16'h0000);
            chipSelectN <= 1'b1;
            readN <= 1'b1;
            tick(4);
        end
        $display("coding test done");
    endtask

    // start and power-down churn during busy; held start never relaunches here
    task automatic t_no_abort();
        for (int m = 0; m < 2; m++) begin
            fastModeSelect <= m[0];
            tick(4);
            fork
                convert(16'h4321, 1'b1, len);
                begin
                    tick(12);
                    powerDownIn <= 1'b1;
                    convertStartN <= 1'b1;
                    tick(5);
                    convertStartN <= 1'b0;
                    tick(5);
                    powerDownIn <= 1'b0;
                end
            join
            chk(16'(len), 16'h0031);
            tick(30);
            chk({15'h0000, busy}, 16'h0000);
            convertStartN <= 1'b1;
            tick(4);
        end
        fastModeSelect <= 1'b0;
        $display("abort test done");
    endtask

    // low-power loop: one falling start, then the block relaunches on its own
    task automatic t_self_run();
        int g;
        g = 0;
        lowPowerModeSelect <= 1'b1;
        outputCodingSelect <= 1'b1;
        chipSelectN <= 1'b0;
        readN <= 1'b0;
        tick(4);
        convert(16'h1234, 1'b1, len);
        chk({15'h0000, converterPowerReduced}, 16'h0001);
        while (busy !== 1'b1 && g < 50) begin
            @(posedge clk);
            g++;
        end
        chk(16'(g), 16'h0009);
        tick(10);
        chk(dataOut, 16'h1234);
        convertStartN <= 1'b1;
        tick(100);
        chk({15'h0000, busy}, 16'h0000);
        chipSelectN <= 1'b1;
        readN <= 1'b1;
        lowPowerModeSelect <= 1'b0;
        $display("self-run test done");
    endtask

    // serial result on bus bit 15, then nothing after the sixteenth pulse
    task automatic t_serial();
        // let the previous test's deselect land before selecting again
        tick(4);
        serialParallelSelect <= 1'b1;
        chipSelectN <= 1'b0;
        readN <= 1'b0;
        convert(16'ha5c3, 1'b0, len);
        tick(4);
        chk(dataOe, 16'h8000);
        i_host_side_model.readWord(word);
        chk(word, 16'ha5c3);
        chk(16'(i_host_side_model.edgeMismatch), 16'h0000);
        tick(8);
        chk({15'h0000, dataOut[15]}, 16'h0000);
        chipSelectN <= 1'b1;
        tick(5);
        chk(dataOe, 16'h0000);
        $display("serial test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        convertStartN = 1'b1;
        powerDownIn = 1'b0;
        lowPowerModeSelect = 1'b0;
        fastModeSelect = 1'b0;
        outputCodingSelect = 1'b1;
        serialParallelSelect = 1'b0;
        chipSelectN = 1'b1;
        readN = 1'b1;
        analogLevel = 16'h0000;
        tick(4);
        srst <= 1'b0;
        tick(4);
        t_coding();
        t_no_abort();
        t_self_run();
        t_serial();
        finish_test();
    end
endmodule // sar_adc_conversion_readout_test
